// ---- core/smc_pkg.sv ----
// Shared constants and types for the stepper motion core.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package smc_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STEP_HZ = 16_000;
    localparam int unsigned STEP_CYC = CLK_HZ / STEP_HZ;
    localparam logic [11:0] TICK_LAST = 12'(STEP_CYC - 1);
    localparam int unsigned VEL_US = 1000;
    localparam int unsigned VEL_CYC_DEF = (CLK_HZ / 1_000_000) * VEL_US;
    localparam int unsigned PD_BYTES = 36;
    localparam int unsigned PD_W = PD_BYTES * 8;
    // Index areas of the object dictionary
    localparam logic [15:0] GEN_LO = 16'h1000;
    localparam logic [15:0] GEN_HI = 16'h6fff;
    localparam logic [15:0] DIO_LO = 16'h7000;
    localparam logic [15:0] DIO_HI = 16'h7fff;
    localparam logic [15:0] AXIS_LO = 16'h8000;
    localparam logic [15:0] AXIS_HI = 16'h8fff;
    localparam logic [15:0] OBJ_IDENT = 16'h1000;
    localparam logic [15:0] OBJ_DIO = 16'h7000;
    localparam logic [15:0] OBJ_AXIS = 16'h8000;
    localparam logic [7:0] IDENT_SUBS = 8'h01;
    localparam logic [7:0] DIO_SUBS = 8'h01;
    localparam logic [7:0] AXIS_SUBS = 8'h06;
    localparam logic [7:0] SUB_CNT = 8'h00;
    localparam logic [7:0] SUB_ID = 8'h01;
    localparam logic [7:0] SUB_LVL = 8'h01;
    localparam logic [7:0] SUB_CTL = 8'h01;
    localparam logic [7:0] SUB_AMP = 8'h02;
    localparam logic [7:0] SUB_LIMP = 8'h03;
    localparam logic [7:0] SUB_LIMN = 8'h04;
    localparam logic [7:0] SUB_POS = 8'h05;
    localparam logic [7:0] SUB_VEL = 8'h06;
    // Arbitrary value, identifies nothing real
    localparam logic [31:0] DEV_ID = 32'h0000_5a01;
    // Control word bits
    localparam int unsigned CTL_EN = 0;
    localparam int unsigned CTL_DIR = 1;
    localparam int unsigned CTL_QUAD = 2;
    localparam int unsigned CTL_LIM = 3;
    // Status byte bits
    localparam int unsigned ST_LIM = 0;
    localparam int unsigned ST_NEG = 1;
    localparam int unsigned ST_ENCERR = 2;
    // Fixed process image layout, bit offsets
    localparam int unsigned PDO_CTL_LSB = 0;
    localparam int unsigned PDO_AMP_LSB = 32;
    localparam int unsigned PDI_POS_LSB = 0;
    localparam int unsigned PDI_VEL_LSB = 32;
    localparam int unsigned PDI_ST_LSB = 64;
    localparam int unsigned PDI_PH_LSB = 72;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [7:0] AMP_RST = 8'h00;
    localparam logic [31:0] LIMP_RST = 32'h7fff_ffff;
    localparam logic [31:0] LIMN_RST = 32'h8000_0000;
    // Micro-step table, a quarter wave of 64 positions
    localparam logic [5:0] PH_QTR = 6'h10;
    localparam logic [4:0] QTR_STEPS = 5'h10;
    localparam logic [16:0][7:0] SIN_Q = {
        8'h7f, 8'h7e, 8'h7d, 8'h7a, 8'h75, 8'h70, 8'h6a, 8'h62, 8'h5a,
        8'h51, 8'h47, 8'h3c, 8'h31, 8'h25, 8'h19, 8'h0c, 8'h00};

    typedef enum logic [1:0] {
        SMC_AREA_NONE, SMC_AREA_GEN, SMC_AREA_DIO, SMC_AREA_AXIS
    } smc_area_t;
    typedef struct packed {
        logic a;
        logic b;
    } smc_enc_t;
    typedef struct packed {
        logic valid;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } smc_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] data;
    } smc_ack_t;
    typedef struct packed {
        smc_enc_t s1;
        smc_enc_t s2;
        smc_enc_t s3;
        smc_enc_t ab;
        logic signed [31:0] pos;
        logic err;
    } smc_quad_st_t;
    typedef struct packed {
        logic [11:0] tick;
        logic [5:0] ph;
        logic [31:0] ctl;
        logic [7:0] amp;
        logic signed [31:0] limp;
        logic signed [31:0] limn;
        logic signed [31:0] prev;
        logic signed [31:0] vel;
        logic [31:0] vcnt;
        logic lim;
        logic encerr;
        smc_ack_t ack;
        logic signed [15:0] csin;
        logic signed [15:0] ccos;
        logic [PD_W-1:0] pdi;
    } smc_core_st_t;
endpackage

// ---- core/smc_quad.sv ----
// Quadrature encoder evaluator with 1-fold and 4-fold counting.
// Assumes raw encoder pins, asynchronous to the clock.
`timescale 1ns/1ps
module smc_quad (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire smc_pkg::smc_enc_t enc_in,
    input wire logic quad_in,
    output smc_pkg::smc_enc_t lvl_out,
    output logic signed [31:0] pos_out,
    output logic err_out
);
    import smc_pkg::*;
    smc_quad_st_t q, d;
    logic take;
    logic up;

    always_comb begin
        d = q;
        d.s1 = enc_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.err = 1'b0;
        take = (q.s2 == q.s3) && (q.s3 != q.ab);
        up = (q.s3.a != q.ab.b) && (q.s3.b == q.ab.a);
        if (take) begin
            d.ab = q.s3;
            if (q.s3.a != q.ab.a && q.s3.b != q.ab.b) begin
                d.err = 1'b1;
            end else if (quad_in) begin
                d.pos = up ? q.pos + 32'sd1 : q.pos - 32'sd1;
            end else if (!q.ab.a && q.s3.a) begin
                d.pos = q.s3.b ? q.pos - 32'sd1 : q.pos + 32'sd1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lvl_out = q.ab;
    assign pos_out = q.pos;
    assign err_out = q.err;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_pos_reset: assert property (
        disable iff (1'b0) !rst_n_in |=> q.pos == 32'sd0)
        else $error("position not cleared by reset");
    a_sync_agree: assert property (
        $changed(q.pos) |-> $past(q.s2 == q.s3))
        else $error("count before sync stages agree");
    a_lead_up: assert property (
        quad_in && take && q.ab == 2'b00 && q.s3 == 2'b10
        |=> q.pos == $past(q.pos) + 32'sd1)
        else $error("A leading did not count up");
    a_lag_down: assert property (
        quad_in && take && q.ab == 2'b00 && q.s3 == 2'b01
        |=> q.pos == $past(q.pos) - 32'sd1)
        else $error("A lagging did not count down");
    a_single_fall: assert property (
        !quad_in && take && q.ab.a && !q.s3.a |=> $stable(q.pos))
        else $error("1-fold counted a falling A edge");
    a_four_edges: assert property (
        quad_in && take && (q.s3.a == q.ab.a) |=> $changed(q.pos))
        else $error("4-fold missed a B edge");
    a_double_hold: assert property (
        take && q.s3 == ~q.ab |=> $stable(q.pos) && q.err)
        else $error("double change altered counter");
    c_double: cover property (take && q.s3 == ~q.ab);
endmodule

// ---- core/smc_core.sv ----
// Stepper motion core: object dictionary, process image, micro-steps,
// encoder. Assumes a host that keeps one acyclic request in flight.
`timescale 1ns/1ps
module smc_core #(
    parameter int unsigned VEL_CYC = smc_pkg::VEL_CYC_DEF
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire smc_pkg::smc_req_t ACYC_REQ_IN,
    output smc_pkg::smc_ack_t ACYC_ACK_OUT,
    input wire logic PD_OUT_STB_IN,
    input wire logic [smc_pkg::PD_W-1:0] PD_OUT_IN,
    output logic [smc_pkg::PD_W-1:0] PD_IN_OUT,
    input wire smc_pkg::smc_enc_t ENC_IN,
    output logic signed [15:0] CUR_SIN_OUT,
    output logic signed [15:0] CUR_COS_OUT,
    output logic LIMIT_OUT
);
    import smc_pkg::*;

    smc_core_st_t q, d;
    smc_enc_t lvl;
    logic signed [31:0] pos;
    logic enc_err;
    logic fire;
    logic vel_take;
    smc_area_t area;
    logic hit;
    logic wr_ok;
    logic [31:0] rdat;

    function automatic smc_area_t area_of(input logic [15:0] idx);
        if (idx >= GEN_LO && idx <= GEN_HI) begin
            return SMC_AREA_GEN;
        end else if (idx >= DIO_LO && idx <= DIO_HI) begin
            return SMC_AREA_DIO;
        end else if (idx >= AXIS_LO && idx <= AXIS_HI) begin
            return SMC_AREA_AXIS;
        end else begin
            return SMC_AREA_NONE;
        end
    endfunction

    function automatic logic signed [7:0] sin64(input logic [5:0] p);
        logic [4:0] k;
        logic [7:0] m;
        k = p[4] ? QTR_STEPS - {1'b0, p[3:0]} : {1'b0, p[3:0]};
        m = SIN_Q[k];
        return p[5] ? -$signed(m) : $signed(m);
    endfunction

    // Amplitude is unsigned, so the sign comes from the table alone
    function automatic logic signed [15:0] scale(
        input logic signed [7:0] s, input logic [7:0] amp);
        logic signed [16:0] pr;
        pr = s * $signed({1'b0, amp});
        return pr[15:0];
    endfunction

    smc_quad u_quad (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .enc_in(ENC_IN),
        .quad_in(q.ctl[CTL_QUAD]),
        .lvl_out(lvl),
        .pos_out(pos),
        .err_out(enc_err)
    );

    always_comb begin
        d = q;
        fire = (q.tick == TICK_LAST);
        d.tick = fire ? 12'h000 : q.tick + 12'h001;
        if (fire && q.ctl[CTL_EN]) begin
            d.ph = q.ctl[CTL_DIR] ? q.ph - 6'h01 : q.ph + 6'h01;
        end
        d.csin = scale(sin64(q.ph), q.amp);
        d.ccos = scale(sin64(6'(q.ph + PH_QTR)), q.amp);

        vel_take = (q.vcnt == 32'(VEL_CYC - 1));
        if (vel_take) begin
            d.vcnt = 32'h0000_0000;
            d.vel = pos - q.prev;
            d.prev = pos;
        end else begin
            d.vcnt = q.vcnt + 32'h0000_0001;
        end

        d.lim = q.ctl[CTL_LIM] && (pos > q.limp || pos < q.limn);

        // Sticky until the next cyclic write; a new error wins the clear
        if (PD_OUT_STB_IN) begin
            d.encerr = 1'b0;
        end
        if (enc_err) begin
            d.encerr = 1'b1;
        end

        // control word and amplitude taken from the image at once
        if (PD_OUT_STB_IN) begin
            d.ctl = PD_OUT_IN[PDO_CTL_LSB +: 32];
            d.amp = PD_OUT_IN[PDO_AMP_LSB +: 8];
        end

        area = area_of(ACYC_REQ_IN.index);
        hit = 1'b0;
        wr_ok = 1'b0;
        rdat = 32'h0000_0000;
        if (area == SMC_AREA_GEN && ACYC_REQ_IN.index == OBJ_IDENT) begin
            hit = 1'b1;
            if (ACYC_REQ_IN.sub == SUB_CNT) begin
                rdat = 32'(IDENT_SUBS);
            end else if (ACYC_REQ_IN.sub == SUB_ID) begin
                rdat = DEV_ID;
            end else begin
                hit = 1'b0;
            end
        end else if (area == SMC_AREA_DIO &&
                     ACYC_REQ_IN.index == OBJ_DIO) begin
            hit = 1'b1;
            if (ACYC_REQ_IN.sub == SUB_CNT) begin
                rdat = 32'(DIO_SUBS);
            end else if (ACYC_REQ_IN.sub == SUB_LVL) begin
                rdat = {30'h0, lvl.a, lvl.b};
            end else begin
                hit = 1'b0;
            end
        end else if (area == SMC_AREA_AXIS &&
                     ACYC_REQ_IN.index == OBJ_AXIS) begin
            hit = 1'b1;
            wr_ok = 1'b1;
            if (ACYC_REQ_IN.sub == SUB_CNT) begin
                rdat = 32'(AXIS_SUBS);
                wr_ok = 1'b0;
            end else if (ACYC_REQ_IN.sub == SUB_CTL) begin
                rdat = q.ctl;
            end else if (ACYC_REQ_IN.sub == SUB_AMP) begin
                rdat = 32'(q.amp);
            end else if (ACYC_REQ_IN.sub == SUB_LIMP) begin
                rdat = q.limp;
            end else if (ACYC_REQ_IN.sub == SUB_LIMN) begin
                rdat = q.limn;
            end else if (ACYC_REQ_IN.sub == SUB_POS) begin
                rdat = pos;
                wr_ok = 1'b0;
            end else if (ACYC_REQ_IN.sub == SUB_VEL) begin
                rdat = q.vel;
                wr_ok = 1'b0;
            end else begin
                hit = 1'b0;
                wr_ok = 1'b0;
            end
        end

        d.ack = '0;
        if (ACYC_REQ_IN.valid) begin
            d.ack.ack = 1'b1;
            d.ack.err = !hit || (ACYC_REQ_IN.wr && !wr_ok);
            d.ack.data = ACYC_REQ_IN.wr ? 32'h0000_0000 : rdat;
            // Acyclic writes land after the cyclic ones, so they win
            if (ACYC_REQ_IN.wr && wr_ok) begin
                if (ACYC_REQ_IN.sub == SUB_CTL) begin
                    d.ctl = ACYC_REQ_IN.data;
                end else if (ACYC_REQ_IN.sub == SUB_AMP) begin
                    d.amp = ACYC_REQ_IN.data[7:0];
                end else if (ACYC_REQ_IN.sub == SUB_LIMP) begin
                    d.limp = ACYC_REQ_IN.data;
                end else begin
                    d.limn = ACYC_REQ_IN.data;
                end
            end
        end

        d.pdi = '0;
        d.pdi[PDI_POS_LSB +: 32] = pos;
        d.pdi[PDI_VEL_LSB +: 32] = q.vel;
        d.pdi[PDI_ST_LSB + ST_LIM] = q.lim;
        d.pdi[PDI_ST_LSB + ST_NEG] = q.vel[31];
        d.pdi[PDI_ST_LSB + ST_ENCERR] = q.encerr;
        d.pdi[PDI_PH_LSB +: 6] = q.ph;
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            q <= '0;
            q.ctl <= CTL_RST;
            q.amp <= AMP_RST;
            q.limp <= LIMP_RST;
            q.limn <= LIMN_RST;
        end else begin
            q <= d;
        end
    end

    assign PD_IN_OUT = q.pdi;
    assign ACYC_ACK_OUT = q.ack;
    assign CUR_SIN_OUT = q.csin;
    assign CUR_COS_OUT = q.ccos;
    assign LIMIT_OUT = q.lim;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_ph_reset: assert property (
        disable iff (1'b0) !RST_N_IN |=> q.ph == 6'h00)
        else $error("phase index not cleared by reset");
    a_step_rate: assert property (
        fire && q.ctl[CTL_EN] && !q.ctl[CTL_DIR]
        |=> q.ph == $past(q.ph) + 6'h01)
        else $error("micro-step did not advance on tick");
    a_step_hold: assert property (
        !fire |=> $stable(q.ph))
        else $error("micro-step moved between ticks");
    a_wrap_64: assert property (
        fire && q.ctl[CTL_EN] && !q.ctl[CTL_DIR] && q.ph == 6'h3f
        |=> q.ph == 6'h00 ##2 CUR_SIN_OUT == 16'sd0)
        else $error("phase did not wrap after 64 positions");
    a_ack_every: assert property (
        ACYC_REQ_IN.valid |=> ACYC_ACK_OUT.ack)
        else $error("acyclic access not acknowledged");
    a_sub0_count: assert property (
        ACYC_REQ_IN.valid && !ACYC_REQ_IN.wr &&
        ACYC_REQ_IN.index == OBJ_AXIS && ACYC_REQ_IN.sub == SUB_CNT
        |=> ACYC_ACK_OUT.data == 32'(AXIS_SUBS) && !ACYC_ACK_OUT.err)
        else $error("subindex 0 did not return count");
    a_area_none: assert property (
        ACYC_REQ_IN.valid && ACYC_REQ_IN.index < GEN_LO
        |=> ACYC_ACK_OUT.err)
        else $error("index outside areas accepted");
    a_limit_flag: assert property (
        q.ctl[CTL_LIM] && pos > q.limp |=> LIMIT_OUT ##0
        PD_IN_OUT[PDI_ST_LSB + ST_LIM] == $past(q.lim))
        else $error("limit overrun not reported");
    a_vel_diff: assert property (
        vel_take |=> q.vel == $past(pos) - $past(q.prev))
        else $error("velocity not count difference");
    a_image_pos: assert property (
        1'b1 |=> PD_IN_OUT[PDI_POS_LSB +: 32] == $past(pos))
        else $error("position not at its fixed place");
    a_cyclic_take: assert property (
        PD_OUT_STB_IN && !ACYC_REQ_IN.valid
        |=> q.ctl == $past(PD_OUT_IN[PDO_CTL_LSB +: 32]) &&
            q.amp == $past(PD_OUT_IN[PDO_AMP_LSB +: 8]))
        else $error("output image not taken as a unit");
    a_step_down: assert property (
        fire && q.ctl[CTL_EN] && q.ctl[CTL_DIR]
        |=> q.ph == $past(q.ph) - 6'h01)
        else $error("micro-step did not step back on tick");
    a_ack_only: assert property (
        !ACYC_REQ_IN.valid |=> !ACYC_ACK_OUT.ack)
        else $error("acknowledge without a request");
    a_ro_refuse: assert property (
        ACYC_REQ_IN.valid && ACYC_REQ_IN.wr &&
        ACYC_REQ_IN.index == OBJ_AXIS && ACYC_REQ_IN.sub == SUB_VEL
        |=> ACYC_ACK_OUT.err && ACYC_ACK_OUT.data == 32'h0000_0000)
        else $error("write to read-only object accepted");
    a_sub0_ident: assert property (
        ACYC_REQ_IN.valid && !ACYC_REQ_IN.wr &&
        ACYC_REQ_IN.index == OBJ_IDENT && ACYC_REQ_IN.sub == SUB_CNT
        |=> ACYC_ACK_OUT.data == 32'(IDENT_SUBS) && !ACYC_ACK_OUT.err)
        else $error("identity subindex 0 did not return count");
    a_limit_off: assert property (
        !q.ctl[CTL_LIM] |=> !LIMIT_OUT)
        else $error("limit reported while disabled");

    c_ack_err: cover property (ACYC_ACK_OUT.ack && ACYC_ACK_OUT.err);
    c_limit: cover property (LIMIT_OUT);
    c_wrap: cover property (fire && q.ctl[CTL_EN] && q.ph == 6'h3f);
    c_enc_err: cover property (q.encerr);
endmodule

// ---- verif/smc_host_model.sv ----
// Host side model: acyclic requests and the cyclic output image.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
module smc_host_model (
    input wire logic clk_in,
    output smc_pkg::smc_req_t req_out,
    output logic pd_stb_out,
    output logic [smc_pkg::PD_W-1:0] pd_out
);
    import smc_pkg::*;

    initial begin
        req_out = '0;
        pd_stb_out = 1'b0;
        pd_out = '0;
    end

    // One request per call, so calls in a row go back to back
    task automatic send(input logic wr, input logic [15:0] ix,
        input logic [7:0] sb, input logic [31:0] d);
        @(posedge clk_in);
        #1 req_out = '{1'b1, wr, ix, sb, d};
    endtask

    // Released lines flip, never keep the last value
    task automatic idle();
        @(posedge clk_in);
        #1 req_out = '{1'b0, ~req_out.wr, ~req_out.index,
            ~req_out.sub, ~req_out.data};
    endtask

    task automatic pd_write(input logic [31:0] ctl, input logic [7:0] amp);
        @(posedge clk_in);
        #1 pd_stb_out = 1'b1;
        pd_out = {{31{8'ha5}}, amp, ctl};
        @(posedge clk_in);
        #1 pd_stb_out = 1'b0;
        pd_out = ~pd_out;
    endtask
endmodule

// ---- verif/tb_stepper_motion_core.sv ----
// Bench for the stepper motion core: dictionary, image, steps, encoder.
// Assumes the velocity window is shortened to 20 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module tb_stepper_motion_core;
    import smc_pkg::*;
    localparam int unsigned VCYC = 20;
    logic clk;
    logic rst_n;
    logic pd_stb;
    logic lim;
    smc_req_t req;
    smc_ack_t ack;
    smc_ack_t e_ack;
    smc_enc_t enc;
    logic [PD_W-1:0] pd_o;
    logic [PD_W-1:0] pd_i;
    logic signed [15:0] cs;
    logic signed [15:0] cc;
    logic [1:0] gray [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    smc_ack_t exp_q[$];
    int n_fail = 0;
    int n_checks = 0;
    int epos = 0;
    int eidx = 0;
    int n;
    logic quad = 1'b0;
    logic [7:0] amp = 8'h00;

    smc_core #(.VEL_CYC(VCYC)) i_smc_core (
        .CLK_IN(clk),
        .RST_N_IN(rst_n),
        .ACYC_REQ_IN(req),
        .ACYC_ACK_OUT(ack),
        .PD_OUT_STB_IN(pd_stb),
        .PD_OUT_IN(pd_o),
        .PD_IN_OUT(pd_i),
        .ENC_IN(enc),
        .CUR_SIN_OUT(cs),
        .CUR_COS_OUT(cc),
        .LIMIT_OUT(lim)
    );

    smc_host_model i_smc_host_model (
        .clk_in(clk),
        .req_out(req),
        .pd_stb_out(pd_stb),
        .pd_out(pd_o)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // each answer matched to the oldest note
    always @(negedge clk) begin
        if (ack.ack === 1'b1) begin
            e_ack = exp_q.size() > 0 ? exp_q.pop_front() : '0;
            `CHK("ack", e_ack, ack)
        end
    end

    task automatic acc(input logic wr, input logic [15:0] ix,
        input logic [7:0] sb, input logic [31:0] d, input logic er,
        input logic [31:0] v);
        exp_q.push_back('{1'b1, er, er ? 32'h0 : v});
        i_smc_host_model.send(wr, ix, sb, d);
    endtask

    task automatic rd(input logic [15:0] ix, input logic [7:0] sb,
        input logic er, input logic [31:0] v);
        acc(1'b0, ix, sb, 32'h0, er, v);
    endtask

    // Bounded wait for every answer owed
    task automatic drain();
        i_smc_host_model.idle();
        for (int i = 0; i < 4 && exp_q.size() > 0; i++) @(negedge clk);
        if (exp_q.size() > 0) begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic pd(input logic [31:0] c);
        i_smc_host_model.pd_write(c, amp);
    endtask

    function automatic logic signed [15:0] wave(input logic [5:0] p);
        logic [15:0] w;
        w = 16'(p[4] ? SIN_Q[16 - p[3:0]] : SIN_Q[p[3:0]]) * 16'(amp);
        return p[5] ? -w : w;
    endfunction

    // one tick, phase and both currents
    task automatic step(input logic [5:0] eph);
        logic [5:0] p0;
        p0 = pd_i[77:72];
        n = 0;
        while (pd_i[77:72] === p0 && n < 3300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3300) begin
            n_fail++;
            complete_run();
        end
        `CHK("phase", eph, pd_i[77:72])
        repeat (3) @(negedge clk);
        `CHK("sine", wave(eph), cs)
        `CHK("cosine", wave(eph + 6'h10), cc)
    endtask

    // Phases hold 5 cycles, above the 2 the counter needs
    task automatic enc_go(input int k, input bit fwd);
        smc_enc_t o;
        int old;
        int ev;
        for (int i = 0; i < k; i++) begin
            o = enc;
            old = epos;
            eidx = fwd ? (eidx + 1) % 4 : (eidx + 3) % 4;
            @(posedge clk);
            #1 enc = smc_enc_t'(gray[eidx]);
            if (quad) epos += fwd ? 1 : -1;
            else if (!o.a && enc.a) epos += enc.b ? -1 : 1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            if (i == 0) `CHK("sync delay", 32'(old), pd_i[31:0])
            if (i == 15) begin
                ev = fwd ? (quad ? 4 : 1) : (quad ? -4 : -1);
                `CHK("velocity", 32'(ev), pd_i[63:32])
                `CHK("vel sign", !fwd, pd_i[65])
            end
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic pos_chk();
        repeat (6) @(negedge clk);
        `CHK("position", 32'(epos), pd_i[31:0])
        rd(OBJ_AXIS, SUB_POS, 1'b0, 32'(epos));
        drain();
    endtask

    initial begin
        void'($urandom(32'h955d15d9));
        rst_n = 1'b0;
        enc = smc_enc_t'(2'b00);
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("reset position", 32'h0, pd_i[31:0])
        `CHK("reset phase", 6'h00, pd_i[77:72])
        rd(OBJ_IDENT, SUB_CNT, 1'b0, 32'(IDENT_SUBS));
        rd(OBJ_IDENT, SUB_ID, 1'b0, DEV_ID);
        rd(OBJ_DIO, SUB_CNT, 1'b0, 32'(DIO_SUBS));
        rd(OBJ_DIO, SUB_LVL, 1'b0, 32'h0);
        rd(OBJ_AXIS, SUB_CNT, 1'b0, 32'(AXIS_SUBS));
        rd(OBJ_AXIS, SUB_CTL, 1'b0, CTL_RST);
        rd(OBJ_AXIS, SUB_AMP, 1'b0, 32'(AMP_RST));
        rd(OBJ_AXIS, SUB_LIMP, 1'b0, LIMP_RST);
        rd(OBJ_AXIS, SUB_LIMN, 1'b0, LIMN_RST);
        rd(OBJ_AXIS, SUB_VEL, 1'b0, 32'h0);
        rd(OBJ_AXIS, 8'h07, 1'b1, 32'h0);
        rd(16'h9000, SUB_CNT, 1'b1, 32'h0);
        rd(16'h0800, SUB_CNT, 1'b1, 32'h0);
        acc(1'b1, OBJ_IDENT, SUB_ID, 32'h1, 1'b1, 32'h0);
        acc(1'b1, OBJ_AXIS, SUB_CNT, 32'h1, 1'b1, 32'h0);
        acc(1'b1, OBJ_AXIS, SUB_VEL, 32'h1, 1'b1, 32'h0);
        acc(1'b1, OBJ_DIO, SUB_LVL, 32'h1, 1'b1, 32'h0);
        amp = 8'($urandom_range(255, 1));
        acc(1'b1, OBJ_AXIS, SUB_AMP, 32'(amp), 1'b0, 32'h0);
        rd(OBJ_AXIS, SUB_AMP, 1'b0, 32'(amp));
        acc(1'b1, OBJ_AXIS, SUB_LIMN, 32'h8000_0001, 1'b0, 32'h0);
        rd(OBJ_AXIS, SUB_LIMN, 1'b0, 32'h8000_0001);
        acc(1'b1, OBJ_AXIS, SUB_CTL, 32'h0000_0008, 1'b0, 32'h0);
        rd(OBJ_AXIS, SUB_CTL, 1'b0, 32'h0000_0008);
        drain();
        // stepping down across zero and back up
        pd(32'h3);
        step(6'h3f);
        step(6'h3e);
        `CHK("tick spacing", STEP_CYC - 3, n)
        pd(32'h1);
        step(6'h3f);
        step(6'h00);
        `CHK("image pad", {(PD_W-78){1'b0}}, pd_i[PD_W-1:78])
        quad = 1'b1;
        pd(32'h4);
        enc_go(16, 1'b1);
        pos_chk();
        enc_go(16, 1'b0);
        pos_chk();
        quad = 1'b0;
        pd(32'h0);
        n = $urandom_range(40, 16);
        enc_go(n, 1'b1);
        pos_chk();
        enc_go(n, 1'b0);
        pos_chk();
        eidx = (eidx + 2) % 4;
        @(posedge clk);
        #1 enc = smc_enc_t'(gray[eidx]);
        pos_chk();
        `CHK("enc error", 1'b1, pd_i[66])
        pd(32'h0);
        repeat (2) @(negedge clk);
        `CHK("enc error clear", 1'b0, pd_i[66])
        // limit is strict, at bound stays low
        quad = 1'b1;
        pd(32'hc);
        acc(1'b1, OBJ_AXIS, SUB_LIMP, 32'(epos + 2), 1'b0, 32'h0);
        drain();
        enc_go(2, 1'b1);
        pos_chk();
        `CHK("limit at bound", 1'b0, lim)
        enc_go(1, 1'b1);
        pos_chk();
        `CHK("limit over", 1'b1, lim)
        `CHK("limit status", 1'b1, pd_i[64])
        enc_go(1, 1'b0);
        pos_chk();
        `CHK("limit back", 1'b0, lim)
        rd(OBJ_DIO, SUB_LVL, 1'b0, 32'(enc));
        drain();
        complete_run();
    end
endmodule
